// ===== rtl/sid_pkg.sv
// shared constants and carriers for the system interrupt and decode block
// assumes a single 40 MHz clock domain and an active-low asynchronous reset
package sid_pkg;
   localparam int SID_CHANNELS = 32;
   localparam int SID_VEC_W = 5;
   localparam int SID_ADDR_W = 24;
   localparam int SID_PERIPHS = 8;
   localparam int SID_REGIONS = 11;
   // interrupt channel assignment
   localparam int CH_LOW_SUPPLY = 0;
   localparam int CH_EXT_PIN = 1;
   localparam int CH_WD_EXPIRY = 2;
   localparam int CH_WD_HALFWAY = 3;
   localparam int CH_SER_ERROR = 4;
   localparam int CH_SER0_RX = 5;
   localparam int CH_SER0_TX = 6;
   localparam int CH_SER1_RX = 7;
   localparam int CH_SER1_TX = 8;
   localparam int CH_PMBUS = 9;
   localparam int CH_CMP_SERBUS = 10;
   localparam int CH_FRONT_END0 = 11;
   localparam int CH_SHORT_TIMER3 = 14;
   localparam int CH_LONG_OVF = 18;
   localparam int CH_CAPTURE1 = 19;
   localparam int CH_RESERVED = 20;
   localparam int CH_CAPTURE0 = 21;
   localparam int CH_COMPARE0 = 22;
   localparam int CH_LIMIT_CLOCK = 23;
   localparam int CH_CONV_DONE = 24;
   localparam int CH_FAULT_MUX = 25;
   localparam int CH_MODULATOR3 = 26;
   localparam int CH_FAULT_PIN = 30;
   localparam int CH_SOFTWARE = 31;
   // address map
   localparam logic [23:0] DEC_REG_BASE = 24'hfff000;
   localparam logic [23:0] DEC_REG_MASK = 24'hffffe0;
   localparam logic [23:0] PERIPH_BASE = 24'hffe000;
   localparam logic [23:0] PERIPH_MASK = 24'hffe000;
   localparam int PERIPH_SEL_LSB = 10;
   localparam int REG_IDX_LSB = 2;
   localparam logic [2:0] REG_FLASH_BASE = 3'h0;
   localparam logic [2:0] REG_ROM_BASE = 3'h1;
   localparam logic [2:0] REG_RAM_BASE = 3'h2;
   localparam logic [2:0] REG_FLASH_SIZE = 3'h3;
   localparam logic [2:0] REG_ROM_SIZE = 3'h4;
   localparam logic [2:0] REG_RAM_SIZE = 3'h5;
   localparam logic [2:0] REG_CLOCK_SPEED = 3'h6;
   // power-on map: rom at zero for boot execution
   localparam logic [23:0] RST_ROM_BASE = 24'h000000;
   localparam logic [23:0] RST_FLASH_BASE = 24'h010000;
   localparam logic [23:0] RST_RAM_BASE = 24'h080000;
   localparam logic [3:0] RST_ROM_SIZE = 4'h3;
   localparam logic [3:0] RST_FLASH_SIZE = 4'h6;
   localparam logic [3:0] RST_RAM_SIZE = 4'h3;
   localparam logic [3:0] SIZE_CODE_MAX = 4'he;
   localparam logic [24:0] SIZE_UNIT = 25'h0000400;
   localparam logic [2:0] RST_CLOCK_SPEED = 3'h0;
   // region index for privilege enables
   localparam int RG_FLASH = 0;
   localparam int RG_ROM = 1;
   localparam int RG_RAM = 2;
   localparam int RG_PERIPH0 = 3;

   typedef struct packed {
      logic low_supply_request;
      logic external_pin_request;
      logic watchdog_expiry_request;
      logic watchdog_halfway_request;
      logic serial_error_request;
      logic serial0_receive_request;
      logic serial0_transmit_request;
      logic serial1_receive_request;
      logic serial1_transmit_request;
      logic pmbus_request;
      logic comparator_and_serial_bus_request;
      logic [2:0] front_end_request;
      logic [3:0] short_timer_request;
      logic long_timer_overflow_request;
      logic capture_one_request;
      logic capture_zero_request;
      logic compare_zero_request;
      logic limit_mode_or_clock_request;
      logic conversion_done_request;
      logic fault_mux_request;
      logic [3:0] modulator_request;
      logic fault_pin_request;
      logic software_request;
   } sid_sources_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic privileged;
      logic [23:0] addr;
      logic [31:0] wdata;
   } sid_cpu_access_s;
endpackage

// ===== rtl/sid_top.sv
// system module: interrupt channels, memory select decoder, peripheral
// selects and system protection unit in one top
// assumes request sources and the processor access port are synchronous to clk
// Function
// R1 - thirty-two independent request inputs; the code has 31, with channel 20 tied low
// R2 - per-channel fast or normal level, fast first
// R3 - vector gives highest pending channel index
// R4 - higher channel number wins precedence
// R5 - individual mask per channel
// R6 - service routine clears pending request first
// R7 - channels 0,1,30,31 fixed sources
// R8 - watchdog expiry on channel 2
// R9 - watchdog halfway on channel 3
// R10 - serial requests on channels 4 to 8
// R11 - channels 9 to 13 bus, front ends
// R12 - timers reversed 14-17, long timer 18-22
// R13 - channels 23,24,25 mode, conversion, fault
// R14 - modulators reversed on channels 26 to 29
// R15 - configurable flash, rom, ram selects
// R16 - power-on map boots from rom
// R17 - decoder register access adds wait state
// R18 - decoder writes only when privileged
// R19 - eight 1 kB peripheral selects, extendable
// R20 - privilege checks raise fault or reset
// R21 - processor clock speed setting
// R22 - pending latched until cleared, masks exclude
`timescale 1ns/1ps
module sid_top
   import sid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire sid_pkg::sid_sources_s sources,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] pending_clear,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] channel_enable,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] fast_select,
   input wire sid_pkg::sid_cpu_access_s cpu,
   input wire logic [sid_pkg::SID_PERIPHS-1:0] periph_extend,
   input wire logic [sid_pkg::SID_REGIONS-1:0] user_allowed,
   input wire logic fault_causes_reset,
   output logic [sid_pkg::SID_CHANNELS-1:0] pending_q,
   output logic fast_request_level_q,
   output logic normal_request_level_q,
   output logic [sid_pkg::SID_VEC_W-1:0] fast_vector_q,
   output logic [sid_pkg::SID_VEC_W-1:0] normal_vector_q,
   output logic flash_select_q,
   output logic rom_select_q,
   output logic ram_select_q,
   output logic [sid_pkg::SID_PERIPHS-1:0] periph_select_q,
   output logic wait_q,
   output logic [31:0] rdata_q,
   output logic access_fault_q,
   output logic reset_request_q,
   output logic [2:0] clock_speed_q
);
   import sid_pkg::*;

   logic [SID_CHANNELS-1:0] raw;
   logic [SID_CHANNELS-1:0] live;
   logic [SID_CHANNELS-1:0] fast_live;
   logic [SID_CHANNELS-1:0] normal_live;
   logic [SID_VEC_W-1:0] fast_vec_d;
   logic [SID_VEC_W-1:0] normal_vec_d;
   logic [23:0] flash_base_q, rom_base_q, ram_base_q;
   logic [3:0] flash_size_q, rom_size_q, ram_size_q;
   logic hit_reg, hit_periph, hit_flash, hit_rom, hit_ram;
   logic [2:0] periph_idx;
   logic [2:0] reg_idx;
   logic need_ext;
   logic first_cycle;
   logic illegal;
   logic [31:0] rdata_d;

   // channel assignment; reversed groups keep the highest unit lowest
   always_comb
   begin
      raw = '0;
      raw[CH_LOW_SUPPLY] = sources.low_supply_request; // [R7]
      raw[CH_EXT_PIN] = sources.external_pin_request; // [R7]
      raw[CH_WD_EXPIRY] = sources.watchdog_expiry_request; // [R8]
      raw[CH_WD_HALFWAY] = sources.watchdog_halfway_request; // [R9]
      raw[CH_SER_ERROR] = sources.serial_error_request; // [R10]
      raw[CH_SER0_RX] = sources.serial0_receive_request; // [R10]
      raw[CH_SER0_TX] = sources.serial0_transmit_request; // [R10]
      raw[CH_SER1_RX] = sources.serial1_receive_request; // [R10]
      raw[CH_SER1_TX] = sources.serial1_transmit_request; // [R10]
      raw[CH_PMBUS] = sources.pmbus_request; // [R11]
      raw[CH_CMP_SERBUS] = sources.comparator_and_serial_bus_request; // [R11]
      for (int i = 0; i < 3; i++)
      begin
         raw[CH_FRONT_END0 + i] = sources.front_end_request[i]; // [R11]
      end
      for (int i = 0; i < 4; i++)
      begin
         raw[CH_SHORT_TIMER3 + i] = sources.short_timer_request[3 - i]; // [R12]
         raw[CH_MODULATOR3 + i] = sources.modulator_request[3 - i]; // [R14]
      end
      raw[CH_LONG_OVF] = sources.long_timer_overflow_request; // [R12]
      raw[CH_CAPTURE1] = sources.capture_one_request; // [R12]
      raw[CH_RESERVED] = 1'b0; // [R12]
      raw[CH_CAPTURE0] = sources.capture_zero_request; // [R12]
      raw[CH_COMPARE0] = sources.compare_zero_request; // [R12]
      raw[CH_LIMIT_CLOCK] = sources.limit_mode_or_clock_request; // [R13]
      raw[CH_CONV_DONE] = sources.conversion_done_request; // [R13]
      raw[CH_FAULT_MUX] = sources.fault_mux_request; // [R13]
      raw[CH_FAULT_PIN] = sources.fault_pin_request; // [R7]
      raw[CH_SOFTWARE] = sources.software_request; // [R7]
   end

   // sticky pending bits; a new request in the clearing cycle survives
   genvar g;
   generate
      for (g = 0; g < SID_CHANNELS; g++)
      begin : g_chan
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               pending_q[g] <= 1'b0;
            end
            else if (raw[g]) // [R1] [R22]
            begin
               pending_q[g] <= 1'b1;
            end
            else if (pending_clear[g]) // [R6] [R22]
            begin
               pending_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign live = pending_q & channel_enable; // [R5] [R22]
   assign fast_live = live & fast_select; // [R2]
   assign normal_live = live & ~fast_select; // [R2]

   // scan upward so the last hit, the highest channel, is kept
   function automatic logic [SID_VEC_W-1:0] top_channel(input logic [SID_CHANNELS-1:0] v);
      logic [SID_VEC_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < SID_CHANNELS; i++)
      begin
         if (v[i])
         begin
            idx = SID_VEC_W'(i); // [R4]
         end
      end
      return idx;
   endfunction

   assign fast_vec_d = top_channel(fast_live); // [R3]
   assign normal_vec_d = top_channel(normal_live); // [R3]

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fast_request_level_q <= 1'b0;
         normal_request_level_q <= 1'b0;
         fast_vector_q <= '0;
         normal_vector_q <= '0;
      end
      else
      begin
         // the core takes the fast level ahead of the normal one
         fast_request_level_q <= |fast_live; // [R2]
         normal_request_level_q <= |normal_live; // [R2]
         fast_vector_q <= fast_vec_d; // [R3]
         normal_vector_q <= normal_vec_d; // [R3]
      end
   end

   // size code n selects 1 kB << n, clamped at 16 MB
   function automatic logic region_hit(input logic [23:0] a, input logic [23:0] base,
                                       input logic [3:0] code);
      logic [24:0] span;
      logic [23:0] mask;
      span = SIZE_UNIT << ((code > SIZE_CODE_MAX) ? SIZE_CODE_MAX : code);
      mask = ~(span[23:0] - 24'h000001);
      return (a & mask) == (base & mask); // [R15]
   endfunction

   always_comb
   begin
      hit_reg = (cpu.addr & DEC_REG_MASK) == DEC_REG_BASE;
      hit_periph = !hit_reg && ((cpu.addr & PERIPH_MASK) == PERIPH_BASE); // [R19]
      hit_flash = !hit_reg && !hit_periph && region_hit(cpu.addr, flash_base_q, flash_size_q);
      hit_rom = !hit_reg && !hit_periph && !hit_flash
                && region_hit(cpu.addr, rom_base_q, rom_size_q);
      hit_ram = !hit_reg && !hit_periph && !hit_flash && !hit_rom
                && region_hit(cpu.addr, ram_base_q, ram_size_q);
      periph_idx = cpu.addr[PERIPH_SEL_LSB +: 3]; // [R19]
      reg_idx = cpu.addr[REG_IDX_LSB +: 3];
      need_ext = hit_reg || (hit_periph && periph_extend[periph_idx]); // [R17] [R19]
      first_cycle = cpu.valid && !wait_q;
      illegal = !(hit_reg || hit_periph || hit_flash || hit_rom || hit_ram); // [R20]
      if (!cpu.privileged)
      begin
         // user mode checked per region against its enable
         if ((hit_flash && !user_allowed[RG_FLASH]) || (hit_rom && !user_allowed[RG_ROM])
             || (hit_ram && !user_allowed[RG_RAM])
             || (hit_periph && !user_allowed[RG_PERIPH0 + int'(periph_idx)]))
         begin
            illegal = 1'b1; // [R20]
         end
      end
      case (reg_idx)
         REG_FLASH_BASE: rdata_d = {8'h00, flash_base_q};
         REG_ROM_BASE: rdata_d = {8'h00, rom_base_q};
         REG_RAM_BASE: rdata_d = {8'h00, ram_base_q};
         REG_FLASH_SIZE: rdata_d = {28'h0000000, flash_size_q};
         REG_ROM_SIZE: rdata_d = {28'h0000000, rom_size_q};
         REG_RAM_SIZE: rdata_d = {28'h0000000, ram_size_q};
         REG_CLOCK_SPEED: rdata_d = {29'h00000000, clock_speed_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   // decoder and clock settings; user writes are dropped silently
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flash_base_q <= RST_FLASH_BASE; // [R16]
         rom_base_q <= RST_ROM_BASE; // [R16]
         ram_base_q <= RST_RAM_BASE; // [R16]
         flash_size_q <= RST_FLASH_SIZE; // [R16]
         rom_size_q <= RST_ROM_SIZE; // [R16]
         ram_size_q <= RST_RAM_SIZE; // [R16]
         clock_speed_q <= RST_CLOCK_SPEED;
      end
      else if (first_cycle && cpu.write && cpu.privileged && hit_reg) // [R18]
      begin
         case (reg_idx)
            REG_FLASH_BASE: flash_base_q <= cpu.wdata[23:0]; // [R15]
            REG_ROM_BASE: rom_base_q <= cpu.wdata[23:0]; // [R15]
            REG_RAM_BASE: ram_base_q <= cpu.wdata[23:0]; // [R15]
            REG_FLASH_SIZE: flash_size_q <= cpu.wdata[3:0]; // [R15]
            REG_ROM_SIZE: rom_size_q <= cpu.wdata[3:0]; // [R15]
            REG_RAM_SIZE: ram_size_q <= cpu.wdata[3:0]; // [R15]
            REG_CLOCK_SPEED: clock_speed_q <= cpu.wdata[2:0]; // [R21]
            default: ;
         endcase
      end
   end

   // one wait state: the core holds its access while wait_q is high
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_q <= 1'b0;
      end
      else
      begin
         wait_q <= first_cycle && need_ext; // [R17] [R19]
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flash_select_q <= 1'b0;
         rom_select_q <= 1'b0;
         ram_select_q <= 1'b0;
         periph_select_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         flash_select_q <= cpu.valid && hit_flash; // [R15]
         rom_select_q <= cpu.valid && hit_rom; // [R15]
         ram_select_q <= cpu.valid && hit_ram; // [R15]
         for (int i = 0; i < SID_PERIPHS; i++)
         begin
            periph_select_q[i] <= cpu.valid && hit_periph && (periph_idx == 3'(i)); // [R19]
         end
         rdata_q <= (cpu.valid && hit_reg && !cpu.write) ? rdata_d : 32'h00000000;
      end
   end

   // fault flagged once per access, not again in its wait cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         access_fault_q <= 1'b0;
         reset_request_q <= 1'b0;
      end
      else
      begin
         access_fault_q <= first_cycle && illegal && !fault_causes_reset; // [R20]
         reset_request_q <= first_cycle && illegal && fault_causes_reset; // [R20]
      end
   end
endmodule

// ===== verification/sid_chk.sv
// assertion checker for the system interrupt and decode top
// assumes it is bound to sid_top and sees only its ports
`timescale 1ns/1ps
module sid_chk
   import sid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire sid_pkg::sid_sources_s sources,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] pending_clear,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] channel_enable,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] fast_select,
   input wire sid_pkg::sid_cpu_access_s cpu,
   input wire logic fault_causes_reset,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] pending_q,
   input wire logic fast_request_level_q,
   input wire logic normal_request_level_q,
   input wire logic [sid_pkg::SID_VEC_W-1:0] fast_vector_q,
   input wire logic [sid_pkg::SID_VEC_W-1:0] normal_vector_q,
   input wire logic [sid_pkg::SID_PERIPHS-1:0] periph_select_q,
   input wire logic wait_q,
   input wire logic access_fault_q,
   input wire logic reset_request_q,
   input wire logic [2:0] clock_speed_q
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_set_lowest: assert property (sources.low_supply_request |=> pending_q[0])
      else $error("low supply request not latched");
   a_chan_reserved: assert property (!pending_q[CH_RESERVED])
      else $error("reserved channel pending");
   a_clear_drop:
      assert property (pending_clear[5] && !sources.serial0_receive_request |=> !pending_q[5])
      else $error("clear did not remove request");
   a_fast_level:
      assert property (fast_request_level_q == |$past(pending_q & channel_enable & fast_select))
      else $error("fast level mismatch");
   a_normal_level:
      assert property (normal_request_level_q
         == |$past(pending_q & channel_enable & ~fast_select))
      else $error("normal level mismatch");
   a_fast_vector: assert property (fast_request_level_q |->
      ($past(pending_q & channel_enable & fast_select) >> fast_vector_q) == 32'h1)
      else $error("fast vector not highest channel");
   a_normal_vector: assert property (normal_request_level_q |->
      ($past(pending_q & channel_enable & ~fast_select) >> normal_vector_q) == 32'h1)
      else $error("normal vector not highest channel");
   a_dec_wait: assert property (cpu.valid && !wait_q &&
      (cpu.addr & DEC_REG_MASK) == DEC_REG_BASE |=> wait_q ##1 !wait_q)
      else $error("decoder access without one wait");
   a_psel_decode: assert property (cpu.valid && cpu.privileged && !wait_q &&
      (cpu.addr & PERIPH_MASK) == PERIPH_BASE && (cpu.addr & DEC_REG_MASK) != DEC_REG_BASE
      |=> periph_select_q == 8'h1 << $past(cpu.addr[12:10]))
      else $error("peripheral select wrong");
   a_fault_cause:
      assert property (access_fault_q |-> $past(cpu.valid && !fault_causes_reset))
      else $error("fault without access");
   a_reset_cause:
      assert property (reset_request_q |-> $past(cpu.valid && fault_causes_reset))
      else $error("reset request without access");
   a_speed_write:
      assert property ($changed(clock_speed_q) |-> $past(cpu.valid && cpu.write && cpu.privileged))
      else $error("clock speed changed without privileged write");
endmodule
bind sid_top sid_chk sid_chk_inst (.clk(clk), .nrst(nrst), .sources(sources),
   .pending_clear(pending_clear), .channel_enable(channel_enable), .fast_select(fast_select),
   .cpu(cpu), .fault_causes_reset(fault_causes_reset), .pending_q(pending_q),
   .fast_request_level_q(fast_request_level_q), .normal_request_level_q(normal_request_level_q),
   .fast_vector_q(fast_vector_q), .normal_vector_q(normal_vector_q),
   .periph_select_q(periph_select_q), .wait_q(wait_q), .access_fault_q(access_fault_q),
   .reset_request_q(reset_request_q), .clock_speed_q(clock_speed_q));

// ===== verification/sid_core_model.sv
// processor-side model: services a raised level by clearing its vector channel
// assumes the design's levels and vectors settle before the falling edge
`timescale 1ns/1ps
module sid_core_model
   import sid_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic service_en,
   input wire logic [sid_pkg::SID_CHANNELS-1:0] extra_clear,
   input wire logic fast_level,
   input wire logic normal_level,
   input wire logic [sid_pkg::SID_VEC_W-1:0] fast_vector,
   input wire logic [sid_pkg::SID_VEC_W-1:0] normal_vector,
   output logic [sid_pkg::SID_CHANNELS-1:0] pending_clear
);
   logic [31:0] serve_q;
   assign pending_clear = serve_q | extra_clear;
   // idle a cycle after each clear: the level falls one cycle after pending
   always_ff @(negedge clk or negedge nrst)
   begin
      if (!nrst)
         serve_q <= '0;
      else if (serve_q != '0)
         serve_q <= '0;
      else if (service_en && fast_level)
         serve_q <= 32'h1 << fast_vector;
      else if (service_en && normal_level)
         serve_q <= 32'h1 << normal_vector;
   end
endmodule

// ===== verification/tb.sv
// self-checking bench for the system interrupt and decode top
// assumes the core model owns servicing clears and the bench drives all else
`timescale 1ns/1ps
module tb;
   import sid_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   sid_sources_s sources = '0;
   logic [31:0] extra_clear = '0, channel_enable = '1, fast_select = '0;
   logic service_en = 1'b0;
   sid_cpu_access_s cpu = '0;
   logic [7:0] periph_extend = '0;
   logic [10:0] user_allowed = '1;
   logic fault_causes_reset = 1'b0;
   logic [31:0] pending_clear, pending_q, rdata_q, rdata_s;
   logic fast_lvl, normal_lvl, flash_sel, rom_sel, ram_sel, wait_q, fault_q, reset_q;
   logic wait_s, fault_s, reset_s;
   logic [4:0] fast_vec, normal_vec;
   logic [7:0] psel, psel_s;
   logic [2:0] clock_speed, mem_s;
   int n_errors = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   sid_top sid_top_inst (.clk(clk), .nrst(nrst), .sources(sources),
      .pending_clear(pending_clear), .channel_enable(channel_enable), .fast_select(fast_select),
      .cpu(cpu), .periph_extend(periph_extend), .user_allowed(user_allowed),
      .fault_causes_reset(fault_causes_reset), .pending_q(pending_q),
      .fast_request_level_q(fast_lvl), .normal_request_level_q(normal_lvl),
      .fast_vector_q(fast_vec), .normal_vector_q(normal_vec), .flash_select_q(flash_sel),
      .rom_select_q(rom_sel), .ram_select_q(ram_sel), .periph_select_q(psel), .wait_q(wait_q),
      .rdata_q(rdata_q), .access_fault_q(fault_q), .reset_request_q(reset_q),
      .clock_speed_q(clock_speed));
   sid_core_model sid_core_model_inst (.clk(clk), .nrst(nrst), .service_en(service_en),
      .extra_clear(extra_clear), .fast_level(fast_lvl), .normal_level(normal_lvl),
      .fast_vector(fast_vec), .normal_vector(normal_vec), .pending_clear(pending_clear));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t ns: %s", $time, what);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // entered at a falling edge; held through the wait state when one is raised
   task automatic access(input logic wr, input logic priv, input logic [23:0] addr,
      input logic [31:0] data);
      cpu = '{valid: 1'b1, write: wr, privileged: priv, addr: addr, wdata: data};
      @(negedge clk);
      {mem_s, psel_s, rdata_s} = {flash_sel, rom_sel, ram_sel, psel, rdata_q};
      {wait_s, fault_s, reset_s} = {wait_q, fault_q, reset_q};
      if (wait_q)
         @(negedge clk);
      cpu = '0;
      @(negedge clk);
   endtask
   task automatic clear_all();
      extra_clear = '1;
      @(negedge clk);
      extra_clear = '0;
   endtask
   task automatic test_map();
      int ch;
      for (int b = 0; b < 31; b++)
      begin
         ch = (b >= 20 || (b >= 11 && b <= 16)) ? 30 - b : (b >= 17 ? b - 6 : 31 - b);
         sources = sid_sources_s'(31'h1 << b);
         @(negedge clk);
         sources = '0;
         repeat (3) @(negedge clk);
         check(pending_q, 32'h1 << ch, "map");
         clear_all();
      end
      sources = '1;
      @(negedge clk);
      sources = '0;
      @(negedge clk);
      check(pending_q, 32'hffef_ffff, "all sources at once");
      clear_all();
      $display("test map done");
   endtask
   task automatic test_priority();
      fast_select = 32'h4000_0000;
      {sources.watchdog_halfway_request, sources.compare_zero_request} = 2'b11;
      sources.fault_pin_request = 1'b1;
      @(negedge clk);
      sources = '0;
      repeat (2) @(negedge clk);
      check({fast_lvl, fast_vec}, {1'h1, 5'h1e}, "fast vector");
      check({normal_lvl, normal_vec}, {1'h1, 5'h16}, "normal vector");
      channel_enable[22] = 1'b0;
      repeat (2) @(negedge clk);
      check(normal_vec, 5'h3, "masked channel skipped");
      service_en <= 1'b1;
      for (int i = 0; i < 10 && pending_clear == '0; i++)
         @(posedge clk);
      check(pending_clear, 32'h4000_0000, "fast level serviced first");
      repeat (12) @(negedge clk);
      check(pending_q, 32'h0040_0000, "after service");
      check({fast_lvl, normal_lvl}, 2'h0, "levels dropped");
      service_en <= 1'b0;
      {channel_enable, fast_select} = {32'hffff_ffff, 32'h0};
      clear_all();
      $display("test priority done");
   endtask
   task automatic test_protect();
      user_allowed = 11'h7dd;
      access(1'b0, 1'b0, 24'h000100, 32'h0);
      check({fault_s, reset_s}, 2'b10, "user access to rom");
      access(1'b0, 1'b0, 24'hffe800, 32'h0);
      check({fault_s, reset_s, psel_s}, 10'h204, "user access to peripheral");
      access(1'b0, 1'b0, 24'h010000, 32'h0);
      check({fault_s, reset_s, mem_s}, 5'b00100, "user access to flash");
      fault_causes_reset = 1'b1;
      access(1'b0, 1'b0, 24'h000100, 32'h0);
      check({fault_s, reset_s}, 2'b01, "user access raises reset");
      access(1'b0, 1'b1, 24'h000100, 32'h0);
      check({fault_s, reset_s, mem_s}, 5'b00010, "privileged rom access");
      {fault_causes_reset, user_allowed} = {1'b0, 11'h7ff};
      $display("test protect done");
   endtask
   task automatic test_periph();
      periph_extend = 8'haa;
      for (int k = 0; k < 8; k++)
      begin
         access(1'b0, 1'b1, 24'hffe100 + (24'(k) << 10), 32'h0);
         check({psel_s, wait_s}, {8'h1 << k, k[0]}, "peripheral select");
      end
      $display("test periph done");
   endtask
   task automatic test_decoder();
      access(1'b0, 1'b1, 24'h080000, 32'h0);
      check(mem_s, 3'b001, "boot map ram");
      access(1'b1, 1'b0, 24'hfff004, 32'h0004_0000);
      check(wait_s, 1'b1, "decoder wait");
      access(1'b0, 1'b1, 24'h040000, 32'h0);
      check({mem_s, fault_s}, 4'b0001, "user write ignored");
      access(1'b1, 1'b1, 24'hfff004, 32'h0004_0000);
      access(1'b0, 1'b1, 24'h040000, 32'h0);
      check(mem_s, 3'b010, "rom moved");
      access(1'b0, 1'b1, 24'h042000, 32'h0);
      check(mem_s, 3'b000, "rom 8 kB limit");
      access(1'b1, 1'b1, 24'hfff010, 32'h4);
      access(1'b0, 1'b1, 24'h042000, 32'h0);
      check(mem_s, 3'b010, "rom 16 kB size");
      access(1'b1, 1'b1, 24'hfff018, 32'h5);
      access(1'b1, 1'b0, 24'hfff018, 32'h2);
      access(1'b0, 1'b1, 24'hfff018, 32'h0);
      check(clock_speed, 3'h5, "clock speed");
      check(rdata_s, 32'h5, "clock speed read back");
      $display("test decoder done");
   endtask
   initial
   begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      test_map();
      test_priority();
      test_protect();
      test_periph();
      test_decoder();
      end_of_test();
   end
   // the tests need well under a thousand cycles; three thousand means a hang
   initial
   begin
      #(25 * 3000);
      n_errors++;
      end_of_test();
   end
endmodule
